// ==== core/dpw_cmd_decoder.sv ====
// Two-wire command decoder for a dual digital potentiometer
`timescale 1ns/100ps
// How it works
// - Register reads and writes take address byte, instruction byte, one data byte.
// - Transfers complete after two bytes and a stop, without a data byte.
// - Setting-to-wiper loads the wiper register; tap follows after response delay.
// - Wiper-to-setting starts a nonvolatile write after stop, lasting the write time.
// - Global transfers act on both pots with the shared setting select.
// - After increment/decrement is acked, master may step freely with SCL pulses.
// - SCL high with SDA high steps the selected wiper up one.
// - SCL high with SDA low steps the selected wiper down one.
// - Address byte needs type code and strap address match to proceed.
// - Reads send eight bits MSB first; a matched address, a valid instruction and write data are acknowledged.
// - Unused instruction bits are ignored.
// - Two select bits choose one of four setting registers.
// - Instruction LSB chooses the pot; global commands ignore it.
// - Upper four instruction bits decode to the nine commands.
// - Address is not acknowledged while a nonvolatile write runs.
module dpw_cmd_decoder #(
   parameter logic [3:0] DEVICE_TYPE_CODE = 4'h3, // Arbitrary value
   parameter int NV_WRITE_CYCLES = dpw_pkg::NV_WRITE_CYC
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [3:0] address_strap_pins,
   output logic sda_out,
   output logic sda_oe,
   output logic [7:0] wiper_tap0,
   output logic [7:0] wiper_tap1,
   output logic nv_write_busy
);
   // ------------------------------------------------------------
   // Pin synchronisers and bus events
   // ------------------------------------------------------------
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic [3:0] strap_m, strap_s;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
         strap_m <= 4'h0;
         strap_s <= 4'h0;
      end else begin
         {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
         strap_m <= address_strap_pins;
         strap_s <= strap_m;
      end
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start = scl_s & scl_d & sda_d & ~sda_s;
   wire stop = scl_s & scl_d & ~sda_d & sda_s;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   dpw_pkg::dpw_state_t state_r, after_r, nxt_after;
   dpw_pkg::dpw_act_t act_r, instr_act;
   logic [3:0] cnt_r;
   logic [7:0] shift_r, data_r, tx_r, tx_src, ld_val, mem_rd, mem_wd;
   logic [1:0] sel_r;
   logic pot_r, rd_wiper_r, exec_pot_r, exec_ph_r, sda_oe_r, nv_busy_r, wrl_pend_r;
   logic [7:0] wiper_r [2];
   logic [7:0] tap_r [2];
   logic [1:0] ld_wiper;
   logic [dpw_pkg::WRL_CW-1:0] wrl_cnt_r;
   logic [dpw_pkg::NV_CW-1:0] nv_cnt_r;

   // ------------------------------------------------------------
   // Byte decode
   // ------------------------------------------------------------
   wire [3:0] op = shift_r[dpw_pkg::OP_MSB:dpw_pkg::OP_LSB];
   wire id_match = (op == DEVICE_TYPE_CODE) && (shift_r[3:0] == strap_s) && !nv_busy_r;
   wire op_rd = (op == dpw_pkg::OP_RD_WIPER) || (op == dpw_pkg::OP_RD_SET);
   wire op_wr = (op == dpw_pkg::OP_WR_WIPER) || (op == dpw_pkg::OP_WR_SET);
   wire op_valid = op_rd || op_wr || (op == dpw_pkg::OP_INCDEC) || (instr_act != dpw_pkg::ACT_NONE);
   wire rx_state = (state_r == dpw_pkg::ST_ID) || (state_r == dpw_pkg::ST_INSTR)
                   || (state_r == dpw_pkg::ST_WDATA);
   wire ack_now = (state_r == dpw_pkg::ST_ID) ? id_match :
                  (state_r == dpw_pkg::ST_INSTR) ? op_valid : 1'b1;

   // Bit 1 of the instruction is never looked at
   assign instr_act = (op == dpw_pkg::OP_WR_WIPER) ? dpw_pkg::ACT_WR_WIPER :
                      (op == dpw_pkg::OP_WR_SET) ? dpw_pkg::ACT_WR_SET :
                      (op == dpw_pkg::OP_S2W) ? dpw_pkg::ACT_S2W :
                      (op == dpw_pkg::OP_W2S) ? dpw_pkg::ACT_W2S :
                      (op == dpw_pkg::OP_GS2W) ? dpw_pkg::ACT_GS2W :
                      (op == dpw_pkg::OP_GW2S) ? dpw_pkg::ACT_GW2S : dpw_pkg::ACT_NONE;
   assign nxt_after = (state_r == dpw_pkg::ST_ID) ? dpw_pkg::ST_INSTR :
                      (state_r != dpw_pkg::ST_INSTR) ? dpw_pkg::ST_HOLD :
                      op_rd ? dpw_pkg::ST_RDATA :
                      op_wr ? dpw_pkg::ST_WDATA :
                      (op == dpw_pkg::OP_INCDEC) ? dpw_pkg::ST_INCDEC : dpw_pkg::ST_HOLD;

   // ------------------------------------------------------------
   // Execution after stop
   // ------------------------------------------------------------
   wire exec_global = (act_r == dpw_pkg::ACT_GS2W) || (act_r == dpw_pkg::ACT_GW2S);
   wire exec_fire = (state_r == dpw_pkg::ST_EXEC) && exec_ph_r;
   wire act_to_wiper = (act_r == dpw_pkg::ACT_S2W) || (act_r == dpw_pkg::ACT_GS2W)
                       || (act_r == dpw_pkg::ACT_WR_WIPER);
   wire act_nv = (act_r == dpw_pkg::ACT_W2S) || (act_r == dpw_pkg::ACT_GW2S)
                 || (act_r == dpw_pkg::ACT_WR_SET);
   wire mem_we = exec_fire && act_nv;
   wire nv_start = exec_fire && act_nv && !(exec_global && !exec_pot_r);
   wire [2:0] mem_waddr = {exec_pot_r, sel_r};
   // Pot in the top address bit, setting select below it
   wire [2:0] mem_raddr = (state_r == dpw_pkg::ST_EXEC) ? mem_waddr :
                          {shift_r[dpw_pkg::POT_BIT], shift_r[dpw_pkg::SEL_MSB:dpw_pkg::SEL_LSB]};
   assign mem_wd = (act_r == dpw_pkg::ACT_WR_SET) ? data_r : wiper_r[exec_pot_r];
   assign ld_val = (act_r == dpw_pkg::ACT_WR_WIPER) ? data_r : mem_rd;
   assign tx_src = rd_wiper_r ? wiper_r[pot_r] : mem_rd;

   dpw_setting_mem u_mem (
      .clock(clock),
      .resetn(resetn),
      .rd_addr(mem_raddr),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wd),
      .rd_data(mem_rd)
   );

   // ------------------------------------------------------------
   // Protocol sequencer
   // ------------------------------------------------------------
   // Bus events are ignored for the few cycles of execution; a start
   // cannot legally follow a stop that quickly at any bus rate.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= dpw_pkg::ST_IDLE;
         after_r <= dpw_pkg::ST_IDLE;
         act_r <= dpw_pkg::ACT_NONE;
         cnt_r <= dpw_pkg::CNT_ZERO;
         shift_r <= 8'h00;
         data_r <= 8'h00;
         tx_r <= 8'h00;
         sel_r <= 2'h0;
         pot_r <= 1'b0;
         rd_wiper_r <= 1'b0;
         exec_pot_r <= 1'b0;
         exec_ph_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (start && state_r != dpw_pkg::ST_EXEC) begin
         state_r <= dpw_pkg::ST_ID;
         act_r <= dpw_pkg::ACT_NONE;
         cnt_r <= dpw_pkg::CNT_ZERO;
         sda_oe_r <= 1'b0;
      end else if (stop && state_r != dpw_pkg::ST_EXEC) begin
         cnt_r <= dpw_pkg::CNT_ZERO;
         sda_oe_r <= 1'b0;
         // A write still short of its data byte is dropped
         if (state_r == dpw_pkg::ST_HOLD && act_r != dpw_pkg::ACT_NONE) begin
            state_r <= dpw_pkg::ST_EXEC;
            exec_pot_r <= exec_global ? 1'b0 : pot_r;
            exec_ph_r <= 1'b0;
         end else begin
            state_r <= dpw_pkg::ST_IDLE;
            act_r <= dpw_pkg::ACT_NONE;
         end
      end else if (state_r == dpw_pkg::ST_EXEC) begin
         exec_ph_r <= ~exec_ph_r;
         if (exec_ph_r && exec_global && !exec_pot_r) begin
            exec_pot_r <= 1'b1;
         end else if (exec_ph_r) begin
            state_r <= dpw_pkg::ST_IDLE;
            act_r <= dpw_pkg::ACT_NONE;
         end
      end else if (state_r == dpw_pkg::ST_RDATA) begin
         if (scl_rise) begin
            cnt_r <= cnt_r + dpw_pkg::CNT_STEP;
         end else if (scl_fall && cnt_r == dpw_pkg::BITS_PER_BYTE) begin
            sda_oe_r <= 1'b0;
            state_r <= dpw_pkg::ST_HOLD;
         end else if (scl_fall && cnt_r != dpw_pkg::CNT_ZERO) begin
            sda_oe_r <= ~tx_r[6];
            tx_r <= {tx_r[6:0], 1'b0};
         end
      end else if (rx_state) begin
         if (scl_rise && cnt_r < dpw_pkg::BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r <= cnt_r + dpw_pkg::CNT_STEP;
         end else if (scl_fall && cnt_r == dpw_pkg::BITS_PER_BYTE) begin
            cnt_r <= dpw_pkg::ACK_SLOT;
            sda_oe_r <= ack_now;
            after_r <= ack_now ? nxt_after : dpw_pkg::ST_HOLD;
            if (ack_now && state_r == dpw_pkg::ST_INSTR) begin
               sel_r <= shift_r[dpw_pkg::SEL_MSB:dpw_pkg::SEL_LSB];
               pot_r <= shift_r[dpw_pkg::POT_BIT];
               rd_wiper_r <= (op == dpw_pkg::OP_RD_WIPER);
               act_r <= instr_act;
            end
            if (state_r == dpw_pkg::ST_WDATA) begin
               data_r <= shift_r;
            end
         end else if (scl_fall && cnt_r == dpw_pkg::ACK_SLOT) begin
            cnt_r <= dpw_pkg::CNT_ZERO;
            state_r <= after_r;
            sda_oe_r <= (after_r == dpw_pkg::ST_RDATA) && !tx_src[7];
            tx_r <= tx_src;
         end
      end
   end

   // ------------------------------------------------------------
   // Wiper registers and stepping
   // ------------------------------------------------------------
   wire step_en = (state_r == dpw_pkg::ST_INCDEC) && scl_rise;
   wire [1:0] step_any;
   wire wiper_chg = |ld_wiper || |step_any;

   for (genvar p = 0; p < 2; p++) begin : g_pot
      wire sel_me = (pot_r == 1'(p));
      wire up = step_en && sel_me && sda_s && (wiper_r[p] != dpw_pkg::WIPER_MAX);
      wire dn = step_en && sel_me && !sda_s && (wiper_r[p] != dpw_pkg::WIPER_MIN);
      logic [7:0] wiper_nxt;
      assign ld_wiper[p] = exec_fire && act_to_wiper && (exec_pot_r == 1'(p));
      assign step_any[p] = up || dn;
      assign wiper_nxt = ld_wiper[p] ? ld_val :
                         up ? wiper_r[p] + dpw_pkg::WIPER_STEP :
                         dn ? wiper_r[p] - dpw_pkg::WIPER_STEP : wiper_r[p];
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            wiper_r[p] <= dpw_pkg::WIPER_RESET;
            tap_r[p] <= dpw_pkg::WIPER_RESET;
         end else begin
            wiper_r[p] <= wiper_nxt;
            if (wrl_pend_r && wrl_cnt_r == '0) begin
               tap_r[p] <= wiper_r[p];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Response delay and nonvolatile write timer
   // ------------------------------------------------------------
   // Any new change restarts the delay, so a burst of steps settles once
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wrl_pend_r <= 1'b0;
         wrl_cnt_r <= '0;
      end else if (wiper_chg) begin
         wrl_pend_r <= 1'b1;
         wrl_cnt_r <= dpw_pkg::WRL_CW'(dpw_pkg::WRL_CYC - 1);
      end else if (wrl_pend_r) begin
         wrl_pend_r <= (wrl_cnt_r != '0);
         wrl_cnt_r <= wrl_cnt_r - dpw_pkg::WRL_CW'(1);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nv_busy_r <= 1'b0;
         nv_cnt_r <= '0;
      end else if (nv_start) begin
         nv_busy_r <= 1'b1;
         nv_cnt_r <= dpw_pkg::NV_CW'(NV_WRITE_CYCLES - 1);
      end else if (nv_busy_r) begin
         nv_busy_r <= (nv_cnt_r != '0);
         nv_cnt_r <= nv_cnt_r - dpw_pkg::NV_CW'(1);
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_r;
   assign wiper_tap0 = tap_r[0];
   assign wiper_tap1 = tap_r[1];
   assign nv_write_busy = nv_busy_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   int busy_len_h;
   logic [7:0] since_chg_h;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy_len_h <= 0;
         since_chg_h <= 8'h00;
      end else begin
         busy_len_h <= nv_busy_r ? busy_len_h + 1 : 0;
         since_chg_h <= wiper_chg ? 8'h00 : since_chg_h + 8'(since_chg_h != 8'hFF);
      end
   end

   wire id_end = (state_r == dpw_pkg::ST_ID) && scl_fall && (cnt_r == dpw_pkg::BITS_PER_BYTE);
   wire up_chk = step_en && sda_s && wiper_r[pot_r] != dpw_pkg::WIPER_MAX;
   wire dn_chk = step_en && !sda_s && wiper_r[pot_r] != dpw_pkg::WIPER_MIN;
   sequence s_fire_pot0;
      exec_fire && exec_global && !exec_pot_r;
   endsequence
   sequence s_fire_pot1;
      exec_pot_r && !exec_ph_r ##1 exec_fire && exec_pot_r;
   endsequence

   a_nack_busy: assert property (id_end && nv_busy_r |=> !sda_oe_r)
      else $error("address acked during nonvolatile write");
   a_ack_match: assert property (id_end && id_match |=> sda_oe_r && cnt_r == dpw_pkg::ACK_SLOT)
      else $error("matching address not acked");
   a_nv_length: assert property ($fell(nv_busy_r) |-> busy_len_h == NV_WRITE_CYCLES)
      else $error("nonvolatile write time wrong");
   a_tap_delay: assert property ($changed(tap_r[0]) |-> since_chg_h == 8'(dpw_pkg::WRL_CYC))
      else $error("tap did not follow after response delay");
   a_step_up: assert property (up_chk |=> wiper_r[pot_r] == $past(wiper_r[pot_r]) + 8'h01)
      else $error("wiper did not step up");
   a_step_down: assert property (dn_chk |=> wiper_r[pot_r] == $past(wiper_r[pot_r]) - 8'h01)
      else $error("wiper did not step down");
   a_sat_top: assert property (step_en && sda_s && wiper_r[pot_r] == dpw_pkg::WIPER_MAX
                               |=> wiper_r[pot_r] == dpw_pkg::WIPER_MAX)
      else $error("wiper wrapped past top");
   a_global_both: assert property (s_fire_pot0 |=> s_fire_pot1)
      else $error("global transfer skipped second pot");
   a_no_data: assert property (stop && state_r == dpw_pkg::ST_WDATA |=> state_r == dpw_pkg::ST_IDLE)
      else $error("write without data byte executed");
   a_xfer_run: assert property (stop && state_r == dpw_pkg::ST_HOLD && act_r != dpw_pkg::ACT_NONE
                                |=> state_r == dpw_pkg::ST_EXEC ##2 state_r != dpw_pkg::ST_HOLD)
      else $error("transfer did not run at stop");
endmodule

// ==== include/dpw_pkg.sv ====
// Shared constants and types for the dual pot wiper command decoder
package dpw_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ = 10000;
   localparam int WRL_US = 10;
   localparam int WRL_CYC = WRL_US * CLK_KHZ / 1000;
   localparam int NV_WRITE_MS = 10;
   localparam int NV_WRITE_CYC = NV_WRITE_MS * CLK_KHZ;
   localparam int WRL_CW = 7;
   localparam int NV_CW = 17;

   // ------------------------------------------------------------
   // Byte framing and fields
   // ------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h9;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_STEP = 4'h1;
   localparam int OP_MSB = 7;
   localparam int OP_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 2;
   localparam int POT_BIT = 0;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'hA;
   localparam logic [3:0] OP_RD_SET = 4'hB;
   localparam logic [3:0] OP_WR_SET = 4'hC;
   localparam logic [3:0] OP_S2W = 4'hD;
   localparam logic [3:0] OP_W2S = 4'hE;
   localparam logic [3:0] OP_GS2W = 4'h1;
   localparam logic [3:0] OP_GW2S = 4'h8;
   localparam logic [3:0] OP_INCDEC = 4'h2;

   // ------------------------------------------------------------
   // Register values
   // ------------------------------------------------------------
   localparam logic [7:0] WIPER_MAX = 8'hFF;
   localparam logic [7:0] WIPER_MIN = 8'h00;
   localparam logic [7:0] WIPER_STEP = 8'h01;
   localparam logic [7:0] WIPER_RESET = 8'h00;
   localparam logic [7:0] SETTING_RESET = 8'h00;
   localparam int SET_DEPTH = 8;
   localparam int SET_AW = 3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ID, ST_INSTR, ST_WDATA, ST_RDATA, ST_INCDEC, ST_HOLD, ST_EXEC
   } dpw_state_t;

   typedef enum logic [2:0] {
      ACT_NONE, ACT_WR_WIPER, ACT_WR_SET, ACT_S2W, ACT_W2S, ACT_GS2W, ACT_GW2S
   } dpw_act_t;
endpackage

// ==== core/dpw_setting_mem.sv ====
// Nonvolatile setting register store, two pots by four settings
`timescale 1ns/100ps
module dpw_setting_mem (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [dpw_pkg::SET_AW-1:0] rd_addr,
   input wire logic wr_en,
   input wire logic [dpw_pkg::SET_AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   logic [7:0] mem_r [dpw_pkg::SET_DEPTH];

   // Reset stands in for the power-up contents
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < dpw_pkg::SET_DEPTH; i++) begin
            mem_r[i] <= dpw_pkg::SETTING_RESET;
         end
         rd_data <= dpw_pkg::SETTING_RESET;
      end else begin
         if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
         end
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule

// ==== verification/dpw_bus_master.sv ====
// Two-wire bus master model that issues instructions to the decoder
`timescale 1ns/100ps
module dpw_bus_master (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // Released bus idles high through the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // ------------------------------------------------------------
   // Bit level, SDA moves only while SCL is low except in start and stop
   // ------------------------------------------------------------
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      sda_low <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(3);
      r = sda;
      tick(1);
      scl <= 1'b0;
   endtask
   task automatic start();
      tick(2);
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(8);
   endtask
   task automatic put_byte(input logic [7:0] d, output logic acked);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      acked = ~r;
   endtask
   task automatic get_byte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(1'b0, r);
   endtask
endmodule

// ==== verification/test_dual_pot_wiper_command_decoder.sv ====
// Self-checking bench for the dual pot wiper command decoder
`timescale 1ns/100ps
module test_dual_pot_wiper_command_decoder;
   localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary value
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] strap = 4'h0;
   logic scl, sda_low, sda_oe, busy;
   logic [7:0] tap0, tap1;
   logic [7:0] wip [2];
   logic [7:0] setm [2][4];
   logic [31:0] lfsr_r = 32'h0000_dfe1;
   int bad_count = 0;
   int checks_done = 0;
   logic sda_drv;
   // Open drain: the device's level reaches the wire only while enabled
   wire sda = ~sda_low & (sda_oe ? sda_drv : 1'b1);

   always #50 clock = ~clock;

   dpw_cmd_decoder #(.DEVICE_TYPE_CODE(TYPE_CODE), .NV_WRITE_CYCLES(200)) uut (
      .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda),
      .address_strap_pins(strap), .sda_out(sda_drv), .sda_oe(sda_oe),
      .wiper_tap0(tap0), .wiper_tap1(tap1), .nv_write_busy(busy));
   dpw_bus_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] ins(logic [3:0] op, logic [1:0] sel, logic p);
      return {op, sel, 1'b0, p};
   endfunction
   function automatic logic [7:0] stepped(logic [7:0] w, logic up);
      if (up) return (w == 8'hff) ? w : w + 8'h01;
      return (w == 8'h00) ? w : w - 8'h01;
   endfunction
   task automatic roll(output logic [7:0] v);
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      v = lfsr_r[7:0];
   endtask
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmd(logic [7:0] i, logic data, logic [7:0] d);
      logic a, b, c;
      m.start();
      m.put_byte({TYPE_CODE, strap}, a);
      m.put_byte(i, b);
      c = 1'b0;
      if (data) m.put_byte(d, c);
      m.stop();
      check("command acks", {5'h00, a, b, c}, {5'h00, 2'b11, data});
   endtask
   task automatic rd(logic [7:0] i, logic [7:0] exp);
      logic a, b;
      logic [7:0] v;
      m.start();
      m.put_byte({TYPE_CODE, strap}, a);
      m.put_byte(i, b);
      m.get_byte(v);
      m.stop();
      check("read acks", {6'h00, a, b}, 8'h03);
      check("read data", v, exp);
   endtask
   task automatic rd_all();
      for (int k = 0; k < 8; k++) begin
         rd(ins(dpw_pkg::OP_RD_SET, k[1:0], k[2]), setm[k[2]][k[1:0]]);
      end
      rd(ins(dpw_pkg::OP_RD_WIPER, 2'b00, 1'b0), wip[0]);
      rd(ins(dpw_pkg::OP_RD_WIPER, 2'b00, 1'b1), wip[1]);
   endtask
   task automatic wait_taps();
      m.tick(110);
      check("tap0", tap0, wip[0]);
      check("tap1", tap1, wip[1]);
   endtask
   task automatic nv_wait();
      logic a;
      int n;
      check("busy after store", {7'h00, busy}, 8'h01);
      m.start();
      m.put_byte({TYPE_CODE, strap}, a);
      m.stop();
      check("poll ack", {7'h00, a}, 8'h00);
      check("busy during poll", {7'h00, busy}, 8'h01);
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         m.tick(1);
         n++;
      end
      check("busy cleared", {7'h00, busy}, 8'h00);
   endtask
   task automatic incdec(logic p, logic [7:0] pat);
      logic a;
      m.start();
      m.put_byte({TYPE_CODE, strap}, a);
      m.put_byte(ins(dpw_pkg::OP_INCDEC, 2'b00, p), a);
      check("step ack", {7'h00, a}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         m.bit_io(pat[i], a);
         wip[p] = stepped(wip[p], pat[i]);
      end
      m.stop();
      wip[p] = stepped(wip[p], 1'b0); // Stop's own SCL rise sees SDA low
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] v;
      logic a;
      logic [3:0] ops [4];
      logic [7:0] starts [3];
      logic [7:0] pats [3];
      roll(v);
      strap <= v[3:0];
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      m.tick(4);
      check("reset taps", tap0 | tap1, 8'h00);
      check("reset busy", {7'h00, busy}, 8'h00);
      wip = '{8'h00, 8'h00};
      foreach (setm[p, s]) setm[p][s] = 8'h00;
      $display("test reset done");
      for (int p = 0; p < 2; p++) begin
         roll(v);
         cmd(ins(dpw_pkg::OP_WR_WIPER, 2'b00, p[0]) | (p ? 8'h02 : 8'h00), 1'b1, v);
         m.tick(50);
         check("tap before delay", p ? tap1 : tap0, wip[p]);
         wip[p] = v;
         wait_taps();
      end
      $display("test write wiper done");
      for (int k = 0; k < 8; k++) begin
         roll(v);
         cmd(ins(dpw_pkg::OP_WR_SET, k[1:0], k[2]), 1'b1, v);
         setm[k[2]][k[1:0]] = v;
         nv_wait();
      end
      rd_all();
      $display("test settings done");
      ops = '{dpw_pkg::OP_S2W, dpw_pkg::OP_GS2W, dpw_pkg::OP_W2S, dpw_pkg::OP_GW2S};
      for (int k = 0; k < 4; k++) begin
         roll(v);
         cmd(ins(ops[k], v[2:1], k[0] ? 1'b0 : v[0]), 1'b0, 8'h00);
         for (int p = 0; p < 2; p++) begin
            if (k[0] || p[0] == v[0]) begin
               if (k[1]) setm[p][v[2:1]] = wip[p];
               else wip[p] = setm[p][v[2:1]];
            end
         end
         if (k[1]) nv_wait();
         else wait_taps();
      end
      rd_all();
      $display("test transfers done");
      for (int k = 0; k < 2; k++) begin
         m.start();
         m.put_byte(k ? {~TYPE_CODE, strap} : {TYPE_CODE, ~strap}, a);
         check("foreign address ack", {7'h00, a}, 8'h00);
         m.put_byte(ins(dpw_pkg::OP_WR_WIPER, 2'b00, 1'b0), a);
         m.put_byte(~wip[0], a);
         m.stop();
      end
      // Write wiper cut short before its data byte must change nothing
      cmd(ins(dpw_pkg::OP_WR_WIPER, 2'b00, 1'b0), 1'b0, 8'h00);
      wait_taps();
      $display("test address match done");
      roll(v);
      starts = '{8'hfd, 8'h02, v};
      pats = '{8'hff, 8'h00, v ^ 8'h5a};
      for (int k = 0; k < 3; k++) begin
         cmd(ins(dpw_pkg::OP_WR_WIPER, 2'b00, k[0]), 1'b1, starts[k]);
         wip[k[0]] = starts[k];
         incdec(k[0], pats[k]);
         wait_taps();
      end
      $display("test stepping done");
      close_out();
   end

   // Roughly four times the expected run of some 15000 cycles
   initial begin
      #(60000 * 100);
      bad_count++;
      close_out();
   end
endmodule
